// [pkg/mcs_pkg.sv]
// shared constants and types for the mic calibration sequencer
package mcs_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // tone windows and completion, in ms from start
    localparam logic [9:0] T_ST1_MS = 10'd10;
    localparam logic [9:0] T_ET1_MS = 10'd200;
    localparam logic [9:0] T_ST2_MS = 10'd215;
    localparam logic [9:0] T_ET2_MS = 10'd400;
    localparam logic [9:0] T_ST3_MS = 10'd415;
    localparam logic [9:0] T_ET3_MS = 10'd600;
    localparam logic [9:0] T_CC_MS = 10'd770;
    localparam logic [9:0] T_PROG_MS = 10'd215;
    localparam logic [9:0] MS_MAX = 10'h3ff;
    // register offsets
    localparam logic [7:0] A_COEF = 8'h0e;
    localparam logic [7:0] A_FREQ = 8'h0f;
    localparam logic [7:0] A_CHAN = 8'h10;
    localparam logic [7:0] A_STORE = 8'h11;
    localparam logic [7:0] A_START = 8'h12;
    localparam int STORE_N_BIT = 7;
    localparam int START_BIT = 0;
    localparam logic [7:0] STORE_RST = 8'h80;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [6:0] COEF_RST = 7'h00;
    // arbitrary bus address
    localparam logic [6:0] I2C_DEV_ADDR = 7'h5a;
    // coefficient memory entries
    localparam logic [1:0] M_COEF = 2'h0;
    localparam logic [1:0] M_FREQ = 2'h1;
    localparam logic [1:0] M_CHAN = 2'h2;
    localparam logic [2:0] LD_DONE = 3'h4;
    localparam logic [1:0] TONE_NONE = 2'h0;
    localparam logic [1:0] TONE_1K = 2'h1;
    localparam logic [1:0] TONE_300 = 2'h2;
    localparam logic [1:0] TONE_3K = 2'h3;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_TONE1 = 3'h1, S_TONE2 = 3'h3, S_TONE3 = 3'h2,
        S_SETTLE = 3'h6, S_PROG = 3'h7, S_DONE = 3'h5, S_MPROG = 3'h4
    } mcs_cal_st_t;
    typedef enum logic [2:0] {
        I_IDLE = 3'h0, I_ADDR = 3'h1, I_ACKA = 3'h3, I_WR = 3'h2,
        I_ACKW = 3'h6, I_RD = 3'h7, I_ACKR = 3'h5
    } mcs_i2c_st_t;
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } mcs_reg_wr_t;
endpackage : mcs_pkg

// [logic/mcs_coef_mem.sv]
// small coefficient store with registered read data
`timescale 1ns/100ps
module mcs_coef_mem (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_we,
    input wire logic [1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [1:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_q [4];
    logic [7:0] rdata_q;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_entry
            logic [7:0] ent_d;
            always_comb begin
                ent_d = (i_we && i_waddr == 2'(g)) ? i_wdata : mem_q[g];
            end
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    mem_q[g] <= (2'(g) == mcs_pkg::M_COEF) ? 8'h00 : mcs_pkg::GAIN_RST;
                end else begin
                    mem_q[g] <= ent_d;
                end
            end
        end
    endgenerate
    always_ff @(posedge i_clk) begin
        rdata_q <= mem_q[i_raddr];
    end
    assign o_rdata = rdata_q;
endmodule : mcs_coef_mem

// [logic/mcs_i2c_slave.sv]
// i2c register slave, scl and sda sampled on the system clock
`timescale 1ns/100ps
module mcs_i2c_slave (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_rd_data,
    output logic o_sda_oe,
    output logic [7:0] o_ptr,
    output mcs_pkg::mcs_reg_wr_t o_wr
);
    mcs_pkg::mcs_i2c_st_t st_q, st_d;
    logic scl_q, sda_q, oe_q, oe_d, first_q, first_d, rw_q, rw_d;
    logic [3:0] bitc_q, bitc_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    mcs_pkg::mcs_reg_wr_t wr_q, wr_d;
    logic rise, fall, start, stop;
    always_comb begin
        rise = i_scl & ~scl_q;
        fall = ~i_scl & scl_q;
        start = scl_q & i_scl & sda_q & ~i_sda;
        stop = scl_q & i_scl & ~sda_q & i_sda;
        st_d = st_q;
        oe_d = oe_q;
        first_d = first_q;
        rw_d = rw_q;
        bitc_d = bitc_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        wr_d = '0;
        if (start) begin
            st_d = mcs_pkg::I_ADDR;
            bitc_d = 4'h0;
            first_d = 1'b1;
            oe_d = 1'b0;
        end else if (stop) begin
            st_d = mcs_pkg::I_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                mcs_pkg::I_ADDR, mcs_pkg::I_WR: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], i_sda};
                        bitc_d = bitc_q + 4'h1;
                    end
                    if (fall && bitc_q == 4'h8) begin
                        bitc_d = 4'h0;
                        oe_d = 1'b1;
                        if (st_q == mcs_pkg::I_ADDR) begin
                            rw_d = sh_q[0];
                            st_d = mcs_pkg::I_ACKA;
                            if (sh_q[7:1] != mcs_pkg::I2C_DEV_ADDR) begin
                                st_d = mcs_pkg::I_IDLE;
                                oe_d = 1'b0;
                            end
                        end else begin
                            st_d = mcs_pkg::I_ACKW;
                            first_d = 1'b0;
                            if (first_q) begin
                                ptr_d = sh_q;
                            end else begin
                                wr_d = '{en: 1'b1, addr: ptr_q, data: sh_q};
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                mcs_pkg::I_ACKA, mcs_pkg::I_ACKW, mcs_pkg::I_ACKR: begin
                    // master nack ends a read burst
                    if (rise && st_q == mcs_pkg::I_ACKR) begin
                        rw_d = ~i_sda;
                    end
                    if (fall) begin
                        if (st_q != mcs_pkg::I_ACKW && rw_q) begin
                            st_d = mcs_pkg::I_RD;
                            sh_d = i_rd_data;
                            oe_d = ~i_rd_data[7];
                        end else if (st_q == mcs_pkg::I_ACKR) begin
                            st_d = mcs_pkg::I_IDLE;
                            oe_d = 1'b0;
                        end else begin
                            st_d = mcs_pkg::I_WR;
                            oe_d = 1'b0;
                        end
                    end
                end
                mcs_pkg::I_RD: begin
                    if (rise) begin
                        bitc_d = bitc_q + 4'h1;
                    end
                    if (fall) begin
                        if (bitc_q == 4'h8) begin
                            st_d = mcs_pkg::I_ACKR;
                            oe_d = 1'b0;
                            bitc_d = 4'h0;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q <= mcs_pkg::I_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            oe_q <= 1'b0;
            first_q <= 1'b0;
            rw_q <= 1'b0;
            bitc_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            wr_q <= '0;
        end else begin
            st_q <= st_d;
            scl_q <= i_scl;
            sda_q <= i_sda;
            oe_q <= oe_d;
            first_q <= first_d;
            rw_q <= rw_d;
            bitc_q <= bitc_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            wr_q <= wr_d;
        end
    end
    assign o_sda_oe = oe_q;
    assign o_ptr = ptr_q;
    assign o_wr = wr_q;
endmodule : mcs_i2c_slave

// [logic/mcs_cal_seq.sv]
// calibration sequencer top: start control, tone windows, eeprom store
// Overview of operation
// - results go to eeprom only if program enable stays high throughout
// - microphone input before calibration start is ignored
// - start bit 0 at 0x12 runs the engine until cleared, reset zero
// - calibrate rising edges ignored while the start bit is set
// - input in the gaps between tones is ignored
// - data stored automatically at sequence end, not before 770 ms
// - match first, then program eeprom for 215 ms if enabled
// - frequency gain: upper nibble 300 Hz, lower nibble 3 kHz
// - channel gain: upper nibble mic two, lower nibble mic one
// - ready rises when programming ends; host then restores pins, strobe
`timescale 1ns/100ps
module mcs_cal_seq #(
    parameter int P_MS_CYCLES = mcs_pkg::MS_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_calibrate,
    input wire logic i_program_enable_pin,
    input wire logic i_auxiliary_control_pin,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [6:0] i_match_coef,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_cal_active,
    output logic o_capture,
    output logic [1:0] o_tone_sel,
    output logic o_charge_pump,
    output logic [7:0] o_freq_gain,
    output logic [7:0] o_chan_gain,
    output logic [6:0] o_coef,
    output logic o_ready
);
    mcs_pkg::mcs_cal_st_t st_q, st_d;
    mcs_pkg::mcs_reg_wr_t wr;
    logic [7:0] ptr, rd_data, mem_rdata, mem_wdata;
    logic [7:0] freq_q, freq_d, chan_q, chan_d, store_q, store_d;
    logic [6:0] coef_q, coef_d;
    logic start_q, start_d, ready_q, ready_d, cal_q, src_i2c_q, src_i2c_d;
    logic pe_ok_q, pe_ok_d, act_q, act_d, cap_q, cap_d, pump_q, pump_d;
    logic [1:0] tone_q, tone_d, wptr_q, wptr_d;
    logic [2:0] ld_q, ld_d;
    logic [15:0] div_q, div_d;
    logic [9:0] ms_q, ms_d;
    logic tick, pin_go, i2c_go, stop_req, mem_we, man_go;

    mcs_i2c_slave u_i2c (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_rd_data(rd_data),
        .o_sda_oe(o_sda_oe),
        .o_ptr(ptr),
        .o_wr(wr)
    );

    mcs_coef_mem u_mem (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_we(mem_we),
        .i_waddr(wptr_q),
        .i_wdata(mem_wdata),
        .i_raddr(ld_q[1:0]),
        .o_rdata(mem_rdata)
    );

    // open drain: only ever pulls low
    assign o_sda_o = 1'b0;

    always_comb begin
        case (ptr)
            mcs_pkg::A_COEF: rd_data = {ready_q, coef_q};
            mcs_pkg::A_FREQ: rd_data = freq_q;
            mcs_pkg::A_CHAN: rd_data = chan_q;
            mcs_pkg::A_STORE: rd_data = store_q;
            mcs_pkg::A_START: rd_data = {7'h00, start_q};
            default: rd_data = 8'h00;
        endcase
    end

    // pin edge masked by start bit
    assign pin_go = i_calibrate & ~cal_q & ~start_q;
    // bus start on 0 to 1
    assign i2c_go = wr.en && wr.addr == mcs_pkg::A_START && wr.data[mcs_pkg::START_BIT]
        && !start_q;
    assign stop_req = src_i2c_q ? !start_q : !i_calibrate;
    // strobe low with pins high starts manual store
    assign man_go = wr.en && wr.addr == mcs_pkg::A_STORE && !wr.data[mcs_pkg::STORE_N_BIT]
        && i_program_enable_pin && i_auxiliary_control_pin && st_q == mcs_pkg::S_IDLE;
    assign tick = div_q == 16'(P_MS_CYCLES - 1);
    assign mem_we = (st_q == mcs_pkg::S_PROG || st_q == mcs_pkg::S_MPROG)
        && ms_q >= mcs_pkg::T_PROG_MS;

    always_comb begin
        case (wptr_q)
            mcs_pkg::M_COEF: mem_wdata = {1'b0, coef_q};
            mcs_pkg::M_FREQ: mem_wdata = freq_q;
            default: mem_wdata = chan_q;
        endcase
    end

    // register file and restore
    always_comb begin
        freq_d = freq_q;
        chan_d = chan_q;
        store_d = store_q;
        start_d = start_q;
        coef_d = coef_q;
        ready_d = ready_q;
        ld_d = ld_q;
        if (ld_q != mcs_pkg::LD_DONE) begin
            ld_d = ld_q + 3'h1;
        end
        // memory entries reload after reset; the same reset clears them to zero
        case (ld_q)
            3'h1: coef_d = mem_rdata[6:0];
            3'h2: freq_d = mem_rdata;
            3'h3: chan_d = mem_rdata;
            default: ;
        endcase
        if (wr.en) begin
            case (wr.addr)
                mcs_pkg::A_FREQ: freq_d = wr.data;
                mcs_pkg::A_CHAN: chan_d = wr.data;
                mcs_pkg::A_STORE: store_d = wr.data;
                mcs_pkg::A_START: start_d = wr.data[mcs_pkg::START_BIT];
                default: ;
            endcase
        end
        if (wr.en && wr.addr == mcs_pkg::A_STORE && wr.data[mcs_pkg::STORE_N_BIT]) begin
            ready_d = 1'b0;
        end
        if (man_go) begin
            coef_d = wr.data[6:0];
            ready_d = 1'b0;
        end
        if (st_q == mcs_pkg::S_SETTLE && ms_q >= mcs_pkg::T_CC_MS) begin
            coef_d = i_match_coef;
        end
        if (mem_we && wptr_q == mcs_pkg::M_CHAN) begin
            ready_d = 1'b1;
        end
    end

    // sequencer
    always_comb begin
        st_d = st_q;
        src_i2c_d = src_i2c_q;
        div_d = (st_q == mcs_pkg::S_IDLE || tick) ? 16'h0000 : div_q + 16'h0001;
        ms_d = (tick && ms_q != mcs_pkg::MS_MAX) ? ms_q + 10'd1 : ms_q;
        wptr_d = mem_we ? wptr_q + 2'h1 : 2'h0;
        // enable must hold for the whole run
        pe_ok_d = pe_ok_q & i_program_enable_pin;
        case (st_q)
            mcs_pkg::S_IDLE: begin
                ms_d = 10'd0;
                if (ld_q == mcs_pkg::LD_DONE && (pin_go || i2c_go)) begin
                    st_d = mcs_pkg::S_TONE1;
                    src_i2c_d = i2c_go;
                    pe_ok_d = i_program_enable_pin;
                end else if (ld_q == mcs_pkg::LD_DONE && man_go) begin
                    st_d = mcs_pkg::S_MPROG;
                end
            end
            mcs_pkg::S_TONE1: begin
                if (ms_q >= mcs_pkg::T_ET1_MS) begin
                    st_d = mcs_pkg::S_TONE2;
                end
            end
            mcs_pkg::S_TONE2: begin
                if (ms_q >= mcs_pkg::T_ET2_MS) begin
                    st_d = mcs_pkg::S_TONE3;
                end
            end
            mcs_pkg::S_TONE3: begin
                if (ms_q >= mcs_pkg::T_ET3_MS) begin
                    st_d = mcs_pkg::S_SETTLE;
                end
            end
            mcs_pkg::S_SETTLE: begin
                if (ms_q >= mcs_pkg::T_CC_MS) begin
                    // program stage only with enable held
                    st_d = (pe_ok_d) ? mcs_pkg::S_PROG : mcs_pkg::S_DONE;
                    ms_d = 10'd0;
                end
            end
            mcs_pkg::S_PROG, mcs_pkg::S_MPROG: begin
                if (mem_we && wptr_q == mcs_pkg::M_CHAN) begin
                    st_d = (st_q == mcs_pkg::S_PROG) ? mcs_pkg::S_DONE : mcs_pkg::S_IDLE;
                end
            end
            default: ;
        endcase
        // an interrupted eeprom write would leave corrupt cells, so it runs out
        if (st_q != mcs_pkg::S_IDLE && st_q != mcs_pkg::S_PROG
            && st_q != mcs_pkg::S_MPROG && stop_req) begin
            st_d = mcs_pkg::S_IDLE;
        end
        act_d = st_d != mcs_pkg::S_IDLE;
        pump_d = st_d == mcs_pkg::S_PROG || st_d == mcs_pkg::S_MPROG;
        cap_d = (st_d == mcs_pkg::S_TONE1 && ms_d >= mcs_pkg::T_ST1_MS)
            || (st_d == mcs_pkg::S_TONE2 && ms_d >= mcs_pkg::T_ST2_MS)
            || (st_d == mcs_pkg::S_TONE3 && ms_d >= mcs_pkg::T_ST3_MS);
        case (st_d)
            mcs_pkg::S_TONE1: tone_d = mcs_pkg::TONE_1K;
            mcs_pkg::S_TONE2: tone_d = mcs_pkg::TONE_300;
            mcs_pkg::S_TONE3: tone_d = mcs_pkg::TONE_3K;
            default: tone_d = mcs_pkg::TONE_NONE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q <= mcs_pkg::S_IDLE;
            src_i2c_q <= 1'b0;
            pe_ok_q <= 1'b0;
            div_q <= 16'h0000;
            ms_q <= 10'd0;
            wptr_q <= 2'h0;
            act_q <= 1'b0;
            cap_q <= 1'b0;
            pump_q <= 1'b0;
            tone_q <= mcs_pkg::TONE_NONE;
            freq_q <= mcs_pkg::GAIN_RST;
            chan_q <= mcs_pkg::GAIN_RST;
            store_q <= mcs_pkg::STORE_RST;
            start_q <= 1'b0;
            coef_q <= mcs_pkg::COEF_RST;
            ready_q <= 1'b0;
            ld_q <= 3'h0;
            cal_q <= 1'b1;
        end else begin
            st_q <= st_d;
            src_i2c_q <= src_i2c_d;
            pe_ok_q <= pe_ok_d;
            div_q <= div_d;
            ms_q <= ms_d;
            wptr_q <= wptr_d;
            act_q <= act_d;
            cap_q <= cap_d;
            pump_q <= pump_d;
            tone_q <= tone_d;
            freq_q <= freq_d;
            chan_q <= chan_d;
            store_q <= store_d;
            start_q <= start_d;
            coef_q <= coef_d;
            ready_q <= ready_d;
            ld_q <= ld_d;
            cal_q <= i_calibrate;
        end
    end

    assign o_cal_active = act_q;
    assign o_capture = cap_q;
    assign o_tone_sel = tone_q;
    assign o_charge_pump = pump_q;
    assign o_freq_gain = freq_q;
    assign o_chan_gain = chan_q;
    assign o_coef = coef_q;
    assign o_ready = ready_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence prog_done_s;
        mem_we && wptr_q == mcs_pkg::M_CHAN;
    endsequence
    sequence enter_prog_s;
        st_q == mcs_pkg::S_SETTLE ##1 st_q == mcs_pkg::S_PROG;
    endsequence

    idle_no_capture_a: assert property (
        st_q == mcs_pkg::S_IDLE && $past(st_q) == mcs_pkg::S_IDLE |-> !o_capture)
        else $error("capture while idle");
    gap_ignored_a: assert property (
        st_q == mcs_pkg::S_TONE2 && ms_q < mcs_pkg::T_ST2_MS ##1 st_q == mcs_pkg::S_TONE2
        && $past(ms_d) < mcs_pkg::T_ST2_MS |-> !o_capture)
        else $error("capture in tone gap");
    bus_start_a: assert property (
        st_q == mcs_pkg::S_IDLE && ld_q == mcs_pkg::LD_DONE && i2c_go
        |=> st_q == mcs_pkg::S_TONE1 ##1 o_cal_active && o_tone_sel == mcs_pkg::TONE_1K)
        else $error("bus start not taken");
    pin_masked_a: assert property (
        start_q && st_q == mcs_pkg::S_IDLE && !i2c_go && !man_go
        && $rose(i_calibrate) |=> st_q == mcs_pkg::S_IDLE)
        else $error("pin edge taken with start bit set");
    prog_needs_pe_a: assert property (
        enter_prog_s |-> pe_ok_q && $past(i_program_enable_pin))
        else $error("eeprom program without enable");
    complete_time_a: assert property (
        enter_prog_s |-> $past(ms_q) >= mcs_pkg::T_CC_MS)
        else $error("completion before 770 ms");
    prog_order_a: assert property (
        $rose(st_q == mcs_pkg::S_PROG) |-> $past(st_q) == mcs_pkg::S_SETTLE
        ##1 o_charge_pump)
        else $error("program stage out of order");
    ready_set_a: assert property (
        prog_done_s |=> o_ready ##1 !o_charge_pump)
        else $error("ready not raised after store");
    tick_gap_a: assert property (
        tick |=> !tick && div_q == 16'h0000)
        else $error("timebase tick malformed");
    tone_order_a: assert property (
        st_q == mcs_pkg::S_TONE2 |-> $past(st_q) inside {mcs_pkg::S_TONE1, mcs_pkg::S_TONE2})
        else $error("tone order broken");
endmodule : mcs_cal_seq

// [bench/mcs_i2c_host.sv]
// i2c master model that writes and reads device registers
`timescale 1ns/100ps
module mcs_i2c_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // each phase lasts four system cycles
    task automatic line(input logic c, input logic d);
        repeat (4) @(negedge i_clk);
        o_scl = c;
        o_sda = d;
    endtask : line
    // sda changes only with scl already low
    task automatic bits(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            line(1'b0, o_sda);
            line(1'b0, b[i]);
            line(1'b1, b[i]);
        end
    endtask : bits
    // ack slot is sent as a released one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        line(1'b1, 1'b0);
        bits({mcs_pkg::I2C_DEV_ADDR, 2'b01});
        bits({a, 1'b1});
        bits({d, 1'b1});
        line(1'b0, o_sda);
        line(1'b0, 1'b0);
        line(1'b1, 1'b0);
        line(1'b1, 1'b1);
    endtask : wr
    // repeated start turns the bus round; the master nacks the one byte
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] v;
        line(1'b1, 1'b0);
        bits({mcs_pkg::I2C_DEV_ADDR, 2'b01});
        bits({a, 1'b1});
        line(1'b0, 1'b1);
        line(1'b1, 1'b1);
        line(1'b1, 1'b0);
        bits({mcs_pkg::I2C_DEV_ADDR, 2'b11});
        // sampled with scl high, long after the device moved sda
        for (int i = 8; i >= 0; i--) begin
            line(1'b0, 1'b1);
            line(1'b0, 1'b1);
            line(1'b1, 1'b1);
            v[i] = i_sda;
        end
        d = v[8:1];
        line(1'b0, 1'b1);
        line(1'b0, 1'b0);
        line(1'b1, 1'b0);
        line(1'b1, 1'b1);
    endtask : rd
endmodule : mcs_i2c_host

// [bench/tb_mcs_cal_seq.sv]
// self-checking bench for the calibration sequencer
`timescale 1ns/100ps
module tb_mcs_cal_seq;
    localparam int P = 20;
    logic clk = 1'b0, rst = 1'b1, cal = 1'b0, pe = 1'b0, aux = 1'b0;
    logic [6:0] mc = 7'h00;
    logic scl, hsda, oe, act, cap, pump, rdy, sdo;
    logic [1:0] tone;
    logic [7:0] fg, cg, r, v;
    logic [6:0] coef;
    // released sda floats to the pull-up level
    wire sda = hsda & ~oe;
    int errors = 0, comparisons = 0, seed = 32'he313, cyc = 0;
    initial forever #10 clk = ~clk;
    mcs_i2c_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
    mcs_cal_seq #(.P_MS_CYCLES(P)) u_dut (.i_clk(clk), .i_reset(rst), .i_calibrate(cal),
        .i_program_enable_pin(pe), .i_auxiliary_control_pin(aux), .i_scl(scl),
        .i_sda(sda), .i_match_coef(mc), .o_sda_o(sdo), .o_sda_oe(oe), .o_cal_active(act),
        .o_capture(cap), .o_tone_sel(tone), .o_charge_pump(pump), .o_freq_gain(fg),
        .o_chan_gain(cg), .o_coef(coef), .o_ready(rdy));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic ms(input int n);
        repeat (n * P) @(negedge clk);
    endtask : ms
    task automatic results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // probe points inside and between the tone windows
    task automatic run_chk(input logic prog, input logic rdy_e);
        int t[6] = '{5, 100, 208, 300, 408, 500};
        logic [2:0] e[6] = '{3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
        int now = 0;
        for (int k = 0; k < 6; k++) begin
            ms(t[k] - now);
            now = t[k];
            chk("tone_cap", {5'h00, tone, cap}, {5'h00, e[k]});
            // a late calibrate edge must not restart a bus run
            if (k == 2)
                cal = 1'b1;
        end
        ms(200);
        chk("settle", {6'h00, pump, cap}, 8'h00);
        ms(200);
        chk("pump", {7'h00, pump}, {7'h00, prog});
        ms(100);
        chk("done", {act, pump, rdy, 5'h00}, {2'b10, rdy_e, 5'h00});
        chk("coef", {1'b0, coef}, {1'b0, mc});
    endtask : run_chk
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            results();
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("rst", {act, cap, pump, rdy, sdo, 3'h0}, 8'h00);
        chk("rst_gain", fg | cg | {1'b0, coef}, 8'h00);
        ms(1);
        u_host.rd(mcs_pkg::A_COEF, v);
        chk("coef_boot", v, 8'h00);
        mc = 7'($random(seed));
        // enable first, then calibrate
        pe = 1'b1;
        @(negedge clk);
        cal = 1'b1;
        run_chk(1'b1, 1'b1);
        cal = 1'b0;
        repeat (4) @(negedge clk);
        chk("pin_stop", {7'h00, act}, 8'h00);
        pe = 1'b0;
        cal = 1'b0;
        ms(1);
        mc = 7'($random(seed));
        u_host.wr(mcs_pkg::A_START, 8'h01);
        run_chk(1'b0, 1'b1);
        u_host.wr(mcs_pkg::A_START, 8'h00);
        chk("bus_stop", {7'h00, act}, 8'h00);
        cal = 1'b0;
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 8'h0f : 8'($random(seed));
            u_host.wr(mcs_pkg::A_FREQ, r);
            u_host.wr(mcs_pkg::A_CHAN, ~r);
            chk("freq", fg, r);
            chk("chan", cg, ~r);
        end
        // store refused while the pins are low
        u_host.wr(mcs_pkg::A_STORE, 8'h00);
        chk("mrefuse", {6'h00, pump, rdy}, 8'h01);
        u_host.rd(mcs_pkg::A_COEF, v);
        chk("coef_rd", v, {1'b1, mc});
        pe = 1'b1;
        aux = 1'b1;
        r = {1'b0, 7'($random(seed))};
        u_host.wr(mcs_pkg::A_STORE, r);
        ms(100);
        chk("mprog", {6'h00, pump, rdy}, 8'h02);
        ms(130);
        chk("mdone", {pump, rdy, 6'h00}, 8'h40);
        chk("mcoef", {1'b0, coef}, {1'b0, r[6:0]});
        u_host.rd(mcs_pkg::A_COEF, v);
        chk("ready_rd", v, {1'b1, r[6:0]});
        pe = 1'b0;
        aux = 1'b0;
        u_host.wr(mcs_pkg::A_STORE, mcs_pkg::STORE_RST);
        chk("ready_clr", {7'h00, rdy}, 8'h00);
        results();
    end
endmodule : tb_mcs_cal_seq
